// [core/srb_pkg.sv]
// Purpose: shared constants for the serial receive/transmit buffer port
// Assumes: 25 MHz clock, word-aligned wishbone registers
// Notes: register byte address is four times the register index
package srb_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   // register indices
   localparam logic [4:0] IDX_PROTOCOL = 5'h01;
   localparam logic [4:0] IDX_BAUD = 5'h02;
   localparam logic [4:0] IDX_WIDTH = 5'h03;
   localparam logic [4:0] IDX_STOP = 5'h04;
   localparam logic [4:0] IDX_PARITY = 5'h05;
   localparam logic [4:0] IDX_ACTIVE = 5'h07;
   localparam logic [4:0] IDX_TX_CHAR = 5'h0a;
   localparam logic [4:0] IDX_TX_FILL = 5'h0b;
   localparam logic [4:0] IDX_RX_PEEK = 5'h0c;
   localparam logic [4:0] IDX_RX_POP = 5'h0d;
   localparam logic [4:0] IDX_RX_FILL = 5'h0e;
   localparam logic [4:0] IDX_RX_HL = 5'h0f;
   localparam logic [4:0] IDX_RX_HB = 5'h10;
   localparam logic [4:0] IDX_RX_WL = 5'h11;
   localparam logic [4:0] IDX_RX_WB = 5'h12;
   localparam logic [4:0] IDX_ERR_CNT = 5'h13;
   // reset and special values
   localparam logic [7:0] PROTO_RST = 8'h03;
   localparam logic [7:0] PROTO_USER = 8'h02;
   localparam logic [31:0] BAUD_RST = 32'h0000_2580;
   localparam logic [3:0] WIDTH_RST = 4'h8;
   localparam logic [3:0] WIDTH_MIN = 4'h5;
   localparam logic [3:0] WIDTH_MAX = 4'h8;
   localparam logic [1:0] STOP_ONE = 2'h1;
   localparam logic [1:0] STOP_TWO = 2'h2;
   localparam logic [2:0] PAR_NONE = 3'h0;
   localparam logic [2:0] PAR_ODD = 3'h1;
   localparam logic [2:0] PAR_EVEN = 3'h2;
   localparam logic [2:0] PAR_MARK = 3'h3;
   localparam logic [2:0] PAR_SPACE = 3'h4;
   localparam logic [31:0] ERR_MAX = 32'h7fff_ffff;
   // half-bit divisor for a supported rate, zero otherwise
   function automatic logic [15:0] srb_half_div(input logic [31:0] baud);
      case (baud)
         32'h0000_0960: srb_half_div = 16'(CLK_HZ / (2 * 32'h0000_0960));
         32'h0000_12c0: srb_half_div = 16'(CLK_HZ / (2 * 32'h0000_12c0));
         32'h0000_2580: srb_half_div = 16'(CLK_HZ / (2 * 32'h0000_2580));
         32'h0000_4b00: srb_half_div = 16'(CLK_HZ / (2 * 32'h0000_4b00));
         32'h0000_9600: srb_half_div = 16'(CLK_HZ / (2 * 32'h0000_9600));
         32'h0000_e100: srb_half_div = 16'(CLK_HZ / (2 * 32'h0000_e100));
         32'h0001_c200: srb_half_div = 16'(CLK_HZ / (2 * 32'h0001_c200));
         default: srb_half_div = 16'h0000;
      endcase
   endfunction : srb_half_div
endpackage : srb_pkg

// [core/srb_tx.sv]
// Purpose: serial character transmitter
// Assumes: settings stable while a character is on the line
// Notes: timing is kept in half-bit steps so 1.5 stop bits fit
`timescale 1ns/100ps
`default_nettype none
module srb_tx (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // settings
   input wire logic [15:0] half_div_in,
   input wire logic [3:0] width_in,
   input wire logic [2:0] parity_in,
   input wire logic [2:0] stop_halves_in,
   // character in
   input wire logic [7:0] data_in,
   input wire logic valid_in,
   output logic ready_out,
   // line
   output logic line_out
);
   import srb_pkg::*;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
      srb_tx_state_type;
   srb_tx_state_type state_r;
   logic [15:0] div_r;
   logic [2:0] halves_r;
   logic [2:0] bit_r;
   logic [7:0] shift_r;
   logic par_r;
   logic line_r;
   logic half_tick;
   logic bit_end;
   logic [2:0] need;
   logic [7:0] mask;
   logic p;
   logic par_bit;
   assign half_tick = (div_r == half_div_in - 16'h0001);
   assign need = (state_r == TX_STOP) ? stop_halves_in : 3'h2;
   assign bit_end = half_tick & (halves_r == need - 3'h1);
   assign mask = 8'hff >> (4'h8 - width_in);
   assign p = ^(data_in & mask);
   assign par_bit = (parity_in == PAR_ODD) ? ~p :  // [R19]
                    (parity_in == PAR_EVEN) ? p :
                    (parity_in == PAR_MARK);
   assign ready_out = (state_r == TX_IDLE);
   assign line_out = line_r;
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_r <= TX_IDLE;
         div_r <= 16'h0000;
         halves_r <= 3'h0;
         bit_r <= 3'h0;
         shift_r <= 8'h00;
         par_r <= 1'b0;
         line_r <= 1'b1;
      end else if (state_r == TX_IDLE) begin
         div_r <= 16'h0000;
         halves_r <= 3'h0;
         if (valid_in) begin
            shift_r <= data_in & mask;
            par_r <= par_bit;
            line_r <= 1'b0;  // start bit low [R21]
            state_r <= TX_START;
         end
      end else begin
         div_r <= half_tick ? 16'h0000 : div_r + 16'h0001;
         if (half_tick) begin
            halves_r <= bit_end ? 3'h0 : halves_r + 3'h1;
         end
         if (bit_end) begin
            unique case (state_r)
               TX_START: begin
                  line_r <= shift_r[0];  // lsb first [R21]
                  shift_r <= shift_r >> 1;
                  bit_r <= 3'h0;
                  state_r <= TX_DATA;
               end
               TX_DATA: begin
                  if (bit_r == 3'(width_in - 4'h1)) begin
                     line_r <= (parity_in == PAR_NONE) ? 1'b1 : par_r;
                     state_r <= (parity_in == PAR_NONE) ? TX_STOP : TX_PAR;
                  end else begin
                     line_r <= shift_r[0];
                     shift_r <= shift_r >> 1;
                     bit_r <= bit_r + 3'h1;
                  end
               end
               TX_PAR: begin
                  line_r <= 1'b1;
                  state_r <= TX_STOP;
               end
               TX_STOP: state_r <= TX_IDLE;  // [R20]
               TX_IDLE: state_r <= TX_IDLE;
            endcase
         end
      end
   end
endmodule : srb_tx
`default_nettype wire

// [core/srb_rx.sv]
// Purpose: serial character receiver
// Assumes: line idles high, sampled at mid-bit
// Notes: characters with parity or stop errors are flagged, not delivered
`timescale 1ns/100ps
`default_nettype none
module srb_rx (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // settings
   input wire logic enable_in,
   input wire logic [15:0] half_div_in,
   input wire logic [3:0] width_in,
   input wire logic [2:0] parity_in,
   // line
   input wire logic line_in,
   // character out
   output logic char_valid_out,
   output logic [7:0] char_out,
   output logic error_out
);
   import srb_pkg::*;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
      srb_rx_state_type;
   srb_rx_state_type state_r;
   logic sync1_r;
   logic sync2_r;
   logic [15:0] div_r;
   logic half_r;
   logic [2:0] bit_r;
   logic [7:0] shift_r;
   logic par_err_r;
   logic valid_r;
   logic err_r;
   logic [7:0] char_r;
   logic half_tick;
   logic sample;
   logic [7:0] data;
   logic exp_par;
   assign half_tick = (div_r == half_div_in - 16'h0001);
   assign sample = half_tick & (half_r | (state_r == RX_START));
   assign data = shift_r >> (4'h8 - width_in);
   assign exp_par = (parity_in == PAR_ODD) ? ~(^data) :
                    (parity_in == PAR_EVEN) ? ^data :
                    (parity_in == PAR_MARK);
   assign char_valid_out = valid_r;
   assign char_out = char_r;
   assign error_out = err_r;
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
      end else begin
         sync1_r <= line_in;
         sync2_r <= sync1_r;
      end
   end
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_r <= RX_IDLE;
         div_r <= 16'h0000;
         half_r <= 1'b0;
         bit_r <= 3'h0;
         shift_r <= 8'h00;
         par_err_r <= 1'b0;
         valid_r <= 1'b0;
         err_r <= 1'b0;
         char_r <= 8'h00;
      end else begin
         valid_r <= 1'b0;
         err_r <= 1'b0;
         if (state_r == RX_IDLE) begin
            div_r <= 16'h0000;
            half_r <= 1'b0;
            par_err_r <= 1'b0;
            if (enable_in & ~sync2_r) begin
               state_r <= RX_START;
            end
         end else begin
            div_r <= half_tick ? 16'h0000 : div_r + 16'h0001;
            if (half_tick) begin
               half_r <= ~half_r | (state_r == RX_START);
            end
            if (sample) begin
               half_r <= 1'b0;
               unique case (state_r)
                  RX_START: begin
                     bit_r <= 3'h0;
                     state_r <= sync2_r ? RX_IDLE : RX_DATA;  // [R21]
                  end
                  RX_DATA: begin
                     shift_r <= {sync2_r, shift_r[7:1]};
                     bit_r <= bit_r + 3'h1;
                     if (bit_r == 3'(width_in - 4'h1)) begin
                        state_r <= (parity_in == PAR_NONE) ? RX_STOP : RX_PAR;
                     end
                  end
                  RX_PAR: begin
                     par_err_r <= (sync2_r != exp_par);  // [R19]
                     state_r <= RX_STOP;
                  end
                  RX_STOP: begin
                     valid_r <= sync2_r & ~par_err_r;
                     err_r <= ~sync2_r | par_err_r;
                     char_r <= data;
                     state_r <= RX_IDLE;
                  end
                  RX_IDLE: state_r <= RX_IDLE;
               endcase
            end
         end
      end
   end
endmodule : srb_rx
`default_nettype wire

// [core/srb_port.sv]
// What this block does
// R01 - pop read returns and removes oldest character
// R02 - returned characters masked to configured width
// R03 - receive fill level counts 0 to 32768
// R04 - pop decrements fill; only when fill nonzero
// R05 - half little: first char bits 7:0
// R06 - half big: first char bits 15:8
// R07 - word little: first char lowest byte
// R08 - word big: first char highest byte
// R09 - half needs fill over 1, word over 3
// R10 - error counter saturates, write clears it
// R11 - activation value 1 enables line traffic
// R12 - protocol value 2 clears both buffers
// R13 - software checks transmit room before writing
// R14 - written character queued then sent on line
// R15 - software checks fill before single pop
// R16 - software checks fill before packed pops
// R17 - transmit buffer is fifo of 32768
// R18 - width 5 to 8, resets to 8
// R19 - parity none odd even mark space, even default
// R20 - two stop setting gives 1.5 at width 5
// R21 - start low, lsb first, parity, stop high
//
// Purpose: register port of a user-programmable serial interface
// Assumes: classic wishbone slave, one 32-bit word per register
// Notes: reads and writes are answered one cycle after the request
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module srb_port #(
   parameter int DEPTH = 32768,
   parameter int AW = 15
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // wishbone slave
   input wire logic [srb_pkg::ADR_W-1:0] wb_adr_in,
   input wire logic [srb_pkg::DAT_W-1:0] wb_dat_in,
   output logic [srb_pkg::DAT_W-1:0] wb_dat_out,
   input wire logic wb_we_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   output logic wb_ack_out,
   // serial line
   input wire logic rxd_in,
   output logic txd_out
);
   import srb_pkg::*;
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] FILL_MAX = CW'(DEPTH);
   logic [7:0] proto_r;
   logic [31:0] baud_r;
   logic [3:0] width_r;
   logic [1:0] stop_r;
   logic [2:0] parity_r;
   logic active_r;
   logic [7:0] tx_last_r;
   logic [31:0] err_cnt_r;
   logic ack_r;
   logic [31:0] dat_r;
   logic [7:0] rx_mem [DEPTH];
   logic [7:0] tx_mem [DEPTH];
   logic [AW-1:0] rx_wp_r;
   logic [AW-1:0] rx_rp_r;
   logic [CW-1:0] rx_cnt_r;
   logic [AW-1:0] tx_wp_r;
   logic [AW-1:0] tx_rp_r;
   logic [CW-1:0] tx_cnt_r;

   // bus decode
   logic req;
   logic hit;
   logic [4:0] idx;
   logic wr_req;
   logic rd_req;
   assign req = wb_cyc_in & wb_stb_in & ~ack_r;
   assign hit = ~wb_adr_in[ADR_W-1];
   assign idx = wb_adr_in[6:2];
   assign wr_req = req & hit & wb_we_in & wb_sel_in[0];
   assign rd_req = req & hit & ~wb_we_in;
   logic wr_proto;
   logic wr_baud;
   logic wr_width;
   logic wr_stop;
   logic wr_par;
   logic wr_act;
   logic wr_tx;
   logic wr_err;
   assign wr_proto = wr_req & (idx == IDX_PROTOCOL);
   assign wr_baud = wr_req & (idx == IDX_BAUD) & (wb_sel_in == 4'hf);
   assign wr_width = wr_req & (idx == IDX_WIDTH);
   assign wr_stop = wr_req & (idx == IDX_STOP);
   assign wr_par = wr_req & (idx == IDX_PARITY);
   assign wr_act = wr_req & (idx == IDX_ACTIVE);
   assign wr_tx = wr_req & (idx == IDX_TX_CHAR);
   assign wr_err = wr_req & (idx == IDX_ERR_CNT);

   // setting validation
   logic width_ok;
   logic stop_ok;
   logic par_ok;
   logic [15:0] new_div;
   logic [15:0] half_div;
   logic [2:0] stop_halves;
   assign width_ok = (wb_dat_in[3:0] >= WIDTH_MIN) &
                     (wb_dat_in[3:0] <= WIDTH_MAX) &
                     (wb_dat_in[7:4] == 4'h0);  // [R18]
   assign stop_ok = (wb_dat_in[7:0] == {6'h00, STOP_ONE}) |
                    (wb_dat_in[7:0] == {6'h00, STOP_TWO});
   assign par_ok = (wb_dat_in[7:0] <= {5'h00, PAR_SPACE});  // [R19]
   assign new_div = srb_half_div(wb_dat_in);
   assign half_div = srb_half_div(baud_r);
   assign stop_halves = (stop_r != STOP_TWO) ? 3'h2 :
                        (width_r == WIDTH_MIN) ? 3'h3 : 3'h4;  // [R20]

   // receive buffer pops
   logic [7:0] cmask;
   logic [7:0] c0;
   logic [7:0] c1;
   logic [7:0] c2;
   logic [7:0] c3;
   logic pop1;
   logic pop2;
   logic pop4;
   logic [2:0] rx_pop_n;
   logic clr;
   assign cmask = 8'hff >> (4'h8 - width_r);  // [R02]
   assign c0 = rx_mem[rx_rp_r] & cmask;
   assign c1 = rx_mem[rx_rp_r + AW'(1)] & cmask;
   assign c2 = rx_mem[rx_rp_r + AW'(2)] & cmask;
   assign c3 = rx_mem[rx_rp_r + AW'(3)] & cmask;
   assign pop1 = rd_req & (idx == IDX_RX_POP) & (rx_cnt_r > CW'(0));  // [R04]
   assign pop2 = rd_req & ((idx == IDX_RX_HL) | (idx == IDX_RX_HB)) &
                 (rx_cnt_r > CW'(1));  // [R09]
   assign pop4 = rd_req & ((idx == IDX_RX_WL) | (idx == IDX_RX_WB)) &
                 (rx_cnt_r > CW'(3));  // [R09]
   assign rx_pop_n = pop4 ? 3'h4 : pop2 ? 3'h2 : pop1 ? 3'h1 : 3'h0;
   assign clr = wr_proto & (wb_dat_in[7:0] == PROTO_USER);  // [R12]

   // serial engines
   logic rx_valid;
   logic [7:0] rx_char;
   logic rx_err;
   logic rx_push;
   logic rx_over;
   logic err_ev;
   logic tx_rdy;
   logic tx_go;
   logic tx_push;
   assign rx_push = rx_valid & active_r & (rx_cnt_r < FILL_MAX) & ~clr;
   assign rx_over = rx_valid & active_r & (rx_cnt_r == FILL_MAX);
   assign err_ev = rx_err | rx_over;
   assign tx_go = tx_rdy & active_r & (tx_cnt_r != CW'(0)) & ~clr;  // [R11]
   assign tx_push = wr_tx & (tx_cnt_r < FILL_MAX) & ~clr;  // [R17]
   srb_rx u_rx (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .enable_in(active_r),
      .half_div_in(half_div),
      .width_in(width_r),
      .parity_in(parity_r),
      .line_in(rxd_in),
      .char_valid_out(rx_valid),
      .char_out(rx_char),
      .error_out(rx_err)
   );
   srb_tx u_tx (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .half_div_in(half_div),
      .width_in(width_r),
      .parity_in(parity_r),
      .stop_halves_in(stop_halves),
      .data_in(tx_mem[tx_rp_r]),
      .valid_in(tx_go),
      .ready_out(tx_rdy),
      .line_out(txd_out)
   );

   // read data selection
   logic [31:0] rd_val;
   assign rd_val =
      (idx == IDX_PROTOCOL) ? {24'h000000, proto_r} :
      (idx == IDX_BAUD) ? baud_r :
      (idx == IDX_WIDTH) ? {28'h0000000, width_r} :
      (idx == IDX_STOP) ? {30'h00000000, stop_r} :
      (idx == IDX_PARITY) ? {29'h00000000, parity_r} :
      (idx == IDX_ACTIVE) ? {31'h00000000, active_r} :
      (idx == IDX_TX_CHAR) ? {24'h000000, tx_last_r} :
      (idx == IDX_TX_FILL) ? 32'(tx_cnt_r) :
      (idx == IDX_RX_FILL) ? 32'(rx_cnt_r) :  // [R03]
      (idx == IDX_RX_PEEK) ? {24'h000000, c0 & {8{rx_cnt_r != CW'(0)}}} :
      pop1 ? {24'h000000, c0} :  // [R01]
      (pop2 & (idx == IDX_RX_HL)) ? {16'h0000, c1, c0} :  // [R05]
      (pop2 & (idx == IDX_RX_HB)) ? {16'h0000, c0, c1} :  // [R06]
      (pop4 & (idx == IDX_RX_WL)) ? {c3, c2, c1, c0} :  // [R07]
      (pop4 & (idx == IDX_RX_WB)) ? {c0, c1, c2, c3} :  // [R08]
      (idx == IDX_ERR_CNT) ? err_cnt_r : 32'h00000000;
   assign wb_ack_out = ack_r;
   assign wb_dat_out = dat_r;

   // bus answer
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
      end else begin
         ack_r <= req;
         if (req) begin
            dat_r <= rd_req ? rd_val : 32'h00000000;
         end
      end
   end

   // settings
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         proto_r <= PROTO_RST;
         baud_r <= BAUD_RST;
         width_r <= WIDTH_RST;  // [R18]
         stop_r <= STOP_ONE;
         parity_r <= PAR_EVEN;  // [R19]
         active_r <= 1'b0;
         tx_last_r <= 8'h00;
      end else begin
         if (wr_proto) proto_r <= wb_dat_in[7:0];
         if (wr_baud && new_div != 16'h0000) baud_r <= wb_dat_in;
         if (wr_width && width_ok) width_r <= wb_dat_in[3:0];
         if (wr_stop && stop_ok) stop_r <= wb_dat_in[1:0];
         if (wr_par && par_ok) parity_r <= wb_dat_in[2:0];
         if (wr_act) active_r <= (wb_dat_in[7:0] == 8'h01);  // [R11]
         if (wr_tx) tx_last_r <= wb_dat_in[7:0] & cmask;
      end
   end

   // error counter: a new error wins over a clearing write
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         err_cnt_r <= 32'h00000000;
      end else if (wr_err) begin
         err_cnt_r <= {31'h00000000, err_ev};  // [R10]
      end else if (err_ev && err_cnt_r != ERR_MAX) begin
         err_cnt_r <= err_cnt_r + 32'h00000001;  // [R10]
      end
   end

   // buffer storage
   always_ff @(posedge clock_in) begin
      if (rx_push) rx_mem[rx_wp_r] <= rx_char;
      if (tx_push) tx_mem[tx_wp_r] <= wb_dat_in[7:0] & cmask;  // [R14]
   end

   // buffer pointers and fill levels
   always_ff @(posedge clock_in) begin
      if (rst_in || clr) begin
         rx_wp_r <= AW'(0);
         rx_rp_r <= AW'(0);
         rx_cnt_r <= CW'(0);
         tx_wp_r <= AW'(0);
         tx_rp_r <= AW'(0);
         tx_cnt_r <= CW'(0);  // [R12]
      end else begin
         if (rx_push) rx_wp_r <= rx_wp_r + AW'(1);
         rx_rp_r <= rx_rp_r + AW'(rx_pop_n);  // [R01]
         rx_cnt_r <= rx_cnt_r + CW'(rx_push) - CW'(rx_pop_n);  // [R04]
         if (tx_push) tx_wp_r <= tx_wp_r + AW'(1);
         if (tx_go) tx_rp_r <= tx_rp_r + AW'(1);  // [R17]
         tx_cnt_r <= tx_cnt_r + CW'(tx_push) - CW'(tx_go);
      end
   end

   // checks
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   sequence s_user_select;
      wr_proto && wb_dat_in[7:0] == PROTO_USER;
   endsequence
   sequence s_both_empty;
      rx_cnt_r == CW'(0) && tx_cnt_r == CW'(0);
   endsequence
   a_clear_buffers: assert property (s_user_select |=> s_both_empty) // [R12]
      else $error("buffers not cleared by protocol write");
   a_pop_one_fill: assert property (pop1 |=> // [R04]
      rx_cnt_r == $past(rx_cnt_r) - CW'(1) + CW'($past(rx_push)))
      else $error("single pop did not lower fill by one");
   a_pop_half_fill: assert property (pop2 |=> // [R09]
      rx_cnt_r == $past(rx_cnt_r) - CW'(2) + CW'($past(rx_push)))
      else $error("half pop did not lower fill by two");
   a_pop_word_fill: assert property (pop4 |=> // [R09]
      rx_cnt_r == $past(rx_cnt_r) - CW'(4) + CW'($past(rx_push)))
      else $error("word pop did not lower fill by four");
   a_pop_empty_hold: assert property ( // [R04]
      rd_req && idx == IDX_RX_POP && rx_cnt_r == CW'(0) && !clr
      |=> rx_cnt_r == CW'($past(rx_push)) && wb_dat_out == 32'h00000000)
      else $error("pop on empty buffer changed state");
   a_fill_bound: assert property (rx_cnt_r <= FILL_MAX) // [R03]
      else $error("receive fill above capacity");
   a_half_order: assert property (pop2 && idx == IDX_RX_HL |=> // [R05]
      wb_ack_out && wb_dat_out[7:0] == $past(c0) &&
      wb_dat_out[15:8] == $past(c1))
      else $error("little half packing wrong");
   a_word_order: assert property (pop4 && idx == IDX_RX_WB |=> // [R08]
      wb_dat_out[31:24] == $past(c0) && wb_dat_out[7:0] == $past(c3))
      else $error("big word packing wrong");
   a_err_clear: assert property (wr_err && !err_ev |=> // [R10]
      err_cnt_r == 32'h00000000)
      else $error("error counter not cleared");
   a_width_range: assert property ( // [R18]
      width_r >= WIDTH_MIN && width_r <= WIDTH_MAX)
      else $error("character width out of range");
   a_tx_inactive: assert property (!active_r |-> !tx_go) // [R11]
      else $error("transmit started while inactive");
endmodule : srb_port
`default_nettype wire

// [test/srb_peer.sv]
// Purpose: serial peer that sends to and listens on the port line
// Assumes: 115200 baud (216 clocks a bit), 8 data bits, even parity
// Notes: parity can be spoiled on request
`timescale 1ns/100ps
`default_nettype none
module srb_peer (
   // clock and lines
   input wire logic clock_in,
   input wire logic line_in,
   output logic line_out
);
   localparam int BITC = 216;
   logic [7:0] got[$];
   logic [7:0] c;
   initial line_out = 1'b1;
   // start low, lsb first, parity, stop high
   task automatic send(input logic [7:0] d, input logic bad);
      logic [10:0] f;
      f = {1'b1, ^d ^ bad, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clock_in);
         line_out <= f[i];
         repeat (BITC - 1) @(posedge clock_in);
      end
   endtask : send
   // mid-bit capture of each character
   always begin
      @(negedge line_in);
      repeat (BITC + BITC / 2) @(posedge clock_in);
      for (int i = 0; i < 8; i++) begin
         c[i] = line_in;
         repeat (BITC) @(posedge clock_in);
      end
      got.push_back(c);
      wait (line_in);
   end
endmodule : srb_peer
`default_nettype wire

// [test/tb_top.sv]
// Purpose: register-level test of the serial buffer port
// Assumes: wishbone answer one cycle after the request
// Notes: small buffer depth, 115200 baud
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import srb_pkg::*;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic we = 1'b0;
   logic [3:0] sel = 4'h0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic [31:0] rdat, v;
   logic ack, txd, rxd;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #20 clock_in = ~clock_in;
   srb_port #(.DEPTH(16), .AW(4)) dut (.clock_in(clock_in),
      .rst_in(rst_in), .wb_adr_in(adr), .wb_dat_in(wdat),
      .wb_dat_out(rdat), .wb_we_in(we), .wb_sel_in(sel), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_ack_out(ack), .rxd_in(rxd), .txd_out(txd));
   srb_peer peer (.clock_in(clock_in), .line_in(txd), .line_out(rxd));
   task automatic close_out;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask : check
   task automatic xfer(input logic [4:0] i, input logic w, input logic [31:0] d);
      @(posedge clock_in);
      adr <= {1'b0, i, 2'b00};
      we <= w;
      wdat <= d;
      sel <= 4'hf;
      cyc <= 1'b1;
      stb <= 1'b1;
      do @(posedge clock_in); while (ack !== 1'b1);
      v = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [4:0] i, input logic [31:0] d);
      xfer(i, 1'b1, d);
   endtask : wr
   task automatic rd(input logic [4:0] i, input logic [31:0] e);
      xfer(i, 1'b0, 32'h0);
      check(v, e);
   endtask : rd
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         failures++;
         close_out();
      end
   end
   initial begin
      repeat (2) @(posedge clock_in);
      rst_in <= 1'b0;
      rd(IDX_PARITY, 32'h2);
      wr(IDX_WIDTH, 32'h9);
      rd(IDX_WIDTH, 32'h8);
      rd(5'h1f, 32'h0);
      wr(IDX_BAUD, 32'h0001_c200);
      wr(IDX_PROTOCOL, 32'h2);
      wr(IDX_ACTIVE, 32'h1);
      for (int i = 1; i < 7; i++) peer.send(8'(8'h11 * i), 1'b0);
      rd(IDX_RX_FILL, 32'h6);
      rd(IDX_RX_HL, 32'h2211);
      rd(IDX_RX_POP, 32'h33);
      rd(IDX_RX_FILL, 32'h3);
      rd(IDX_RX_HB, 32'h4455);
      rd(IDX_RX_WL, 32'h0);
      rd(IDX_RX_FILL, 32'h1);
      for (int i = 7; i < 11; i++) peer.send(8'(8'h11 * i), 1'b0);
      rd(IDX_RX_WB, 32'h6677_8899);
      $display("test packed reads done");
      peer.send(8'h5a, 1'b1);
      rd(IDX_ERR_CNT, 32'h1);
      wr(IDX_ERR_CNT, 32'h0);
      rd(IDX_ERR_CNT, 32'h0);
      for (int i = 11; i < 14; i++) peer.send(8'(8'h11 * i), 1'b0);
      rd(IDX_RX_WL, 32'hddcc_bbaa);
      wr(IDX_PARITY, 32'h1);
      peer.send(8'h5a, 1'b1);
      rd(IDX_ERR_CNT, 32'h0);
      wr(IDX_WIDTH, 32'h5);
      rd(IDX_RX_PEEK, 32'h1a);
      wr(IDX_WIDTH, 32'h8);
      wr(IDX_PARITY, 32'h2);
      peer.send(8'hee, 1'b0);
      rd(IDX_RX_FILL, 32'h2);
      wr(IDX_PROTOCOL, 32'h2);
      rd(IDX_RX_FILL, 32'h0);
      rd(IDX_RX_POP, 32'h0);
      $display("test errors and clear done");
      rd(IDX_TX_FILL, 32'h0);
      wr(IDX_TX_CHAR, 32'h5a);
      wr(IDX_TX_CHAR, 32'hc3);
      for (int n = 0; n < 6000 && peer.got.size() < 2; n++)
         @(posedge clock_in);
      check({24'h0, peer.got[0]}, 32'h5a);
      check({24'h0, peer.got[1]}, 32'hc3);
      $display("test transmit done");
      close_out();
   end
endmodule : tb_top
`default_nettype wire
